//--- src/annp_pkg.sv
`default_nettype none
package annp_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int unsigned ANNP_IDX_TX     = 7;
  localparam int unsigned ANNP_IDX_RX     = 8;
  localparam logic [7:0]  ANNP_ADDR_TX    = 8'h1c;
  localparam logic [7:0]  ANNP_ADDR_RX    = 8'h20;
  localparam logic [7:0]  ANNP_ADDR_EXP   = 8'h18;
  localparam logic [7:0]  ANNP_ADDR_ISTAT = 8'h40;
  localparam logic [7:0]  ANNP_ADDR_IMASK = 8'h44;
  localparam logic [7:0]  ANNP_ADDR_CTRL  = 8'h48;
  // ****************************************
  // page fields
  // ****************************************
  localparam int unsigned ANNP_B_MORE   = 15;
  localparam int unsigned ANNP_B_ACK    = 14;
  localparam int unsigned ANNP_B_MSG    = 13;
  localparam int unsigned ANNP_B_COMPLY = 12;
  localparam int unsigned ANNP_B_TOG    = 11;
  localparam int unsigned ANNP_CODE_W   = 11;
  localparam int unsigned ANNP_B_PGRX   = 1;
  localparam logic [10:0] ANNP_NULL_CODE = 11'h001;
  localparam logic        ANNP_MSG_RST   = 1'b1;
  // interrupt bits
  localparam int unsigned ANNP_I_PGRX = 0;
  localparam int unsigned ANNP_I_SENT = 1;
  localparam int unsigned ANNP_I_W    = 2;
  // control bits
  localparam int unsigned ANNP_B_GO   = 0;
  typedef enum logic [1:0] {
    ANNP_ST_IDLE = 2'b01,
    ANNP_ST_SEND = 2'b10
  } annp_state_t;
endpackage
`default_nettype wire

//--- src/annp_regs.sv
// Local design decision: the APB slave port.
`default_nettype none
module annp_regs (
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_resetn,
  // apb slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [7:0]              i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // link partner page exchange (same clock)
  input  wire logic                    i_rx_valid,
  input  wire logic [15:0]             i_rx_word,
  input  wire logic                    i_tx_taken,
  output logic                         o_tx_valid,
  output logic      [15:0]             o_tx_word,
  // interrupt
  output logic                         o_irq
);
  import annp_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic                    more_r, msg_r, comply_r, ack_r, tog_r;
  logic [ANNP_CODE_W-1:0]  code_r;
  logic [15:0]             rxpg_r;
  logic                    pgrx_r, send_req_r;
  logic [ANNP_I_W-1:0]     istat_r, imask_r;
  annp_state_t             state_r;

  logic acc, wr, rd;
  assign acc = i_psel & i_penable;
  assign wr  = acc & i_pwrite;
  assign rd  = acc & ~i_pwrite;

  function automatic logic [15:0] tx_image(input logic m, a, p, c, t,
                                           input logic [10:0] cd);
    tx_image = {m, a, p, c, t, cd};
  endfunction

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      more_r   <= 1'b0;
      msg_r    <= ANNP_MSG_RST;
      comply_r <= 1'b0;
      code_r   <= ANNP_NULL_CODE;
    end else if (wr && i_paddr == ANNP_ADDR_TX) begin
      more_r   <= i_pwdata[ANNP_B_MORE];
      msg_r    <= i_pwdata[ANNP_B_MSG];
      comply_r <= i_pwdata[ANNP_B_COMPLY];
      code_r   <= i_pwdata[ANNP_CODE_W-1:0];
    end
  end

  // start request; a write of one to ctrl bit 0 launches the page
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      send_req_r <= 1'b0;
    end else begin
      send_req_r <= wr && i_paddr == ANNP_ADDR_CTRL && i_pwdata[ANNP_B_GO];
    end
  end

  // ****************************************
  // transmit handshake
  // ****************************************
  // current register contents go out as the next page
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r    <= ANNP_ST_IDLE;
      o_tx_valid <= 1'b0;
      o_tx_word  <= 16'h0000;
    end else begin
      case (state_r)
        ANNP_ST_IDLE: begin
          if (send_req_r) begin
            state_r    <= ANNP_ST_SEND;
            o_tx_valid <= 1'b1;
            o_tx_word  <= tx_image(more_r, ack_r, msg_r, comply_r,
                                   tog_r, code_r);
          end
        end
        ANNP_ST_SEND: begin
          if (i_tx_taken) begin
            state_r    <= ANNP_ST_IDLE;
            o_tx_valid <= 1'b0;
          end
        end
        default: begin
          state_r    <= ANNP_ST_IDLE;
          o_tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // toggle follows inverse of last exchanged word's toggle
  // acknowledge high once a partner word has been received
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tog_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      if (state_r == ANNP_ST_SEND && i_tx_taken) begin
        tog_r <= ~o_tx_word[ANNP_B_TOG];
        ack_r <= 1'b0;
      end
      if (i_rx_valid) begin
        ack_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // receive capture
  // ****************************************
  // word captured whole
  // code meaning rides on the captured page-type bit
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxpg_r <= {2'b00, ANNP_MSG_RST, 2'b00, ANNP_NULL_CODE};
    end else if (i_rx_valid) begin
      rxpg_r <= i_rx_word;
    end
  end

  // clear only what the read reported: read data is latched in the
  // setup cycle, so a word landing there must survive the access edge
  logic pgrx_seen;
  assign pgrx_seen = o_prdata[ANNP_B_PGRX];

  // set on arrival wins over clear-on-read
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pgrx_r <= 1'b0;
    end else if (i_rx_valid) begin
      pgrx_r <= 1'b1;
    end else if (rd && i_paddr == ANNP_ADDR_EXP && pgrx_seen) begin
      pgrx_r <= 1'b0;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [ANNP_I_W-1:0] ev;
  assign ev = {state_r == ANNP_ST_SEND && i_tx_taken, i_rx_valid};

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      istat_r <= '0;
      imask_r <= '0;
    end else begin
      if (wr && i_paddr == ANNP_ADDR_ISTAT) begin
        istat_r <= (istat_r & ~i_pwdata[ANNP_I_W-1:0]) | ev;
      end else begin
        istat_r <= istat_r | ev;
      end
      if (wr && i_paddr == ANNP_ADDR_IMASK) begin
        imask_r <= i_pwdata[ANNP_I_W-1:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(istat_r & imask_r);
    end
  end

  // ****************************************
  // apb read path; zero-wait, registered pready
  // ****************************************
  logic [31:0] rdat;
  logic        bad;
  always_comb begin
    rdat = 32'h0000_0000;
    bad  = 1'b0;
    if (i_paddr == ANNP_ADDR_TX) begin
      rdat[15:0] = tx_image(more_r, ack_r, msg_r, comply_r, tog_r, code_r);
    end else if (i_paddr == ANNP_ADDR_RX) begin
      rdat[15:0] = rxpg_r;
    end else if (i_paddr == ANNP_ADDR_EXP) begin
      rdat[ANNP_B_PGRX] = pgrx_r;
    end else if (i_paddr == ANNP_ADDR_ISTAT) begin
      rdat[ANNP_I_W-1:0] = istat_r;
    end else if (i_paddr == ANNP_ADDR_IMASK) begin
      rdat[ANNP_I_W-1:0] = imask_r;
    end else if (i_paddr == ANNP_ADDR_CTRL) begin
      rdat[ANNP_B_GO] = state_r == ANNP_ST_SEND;
    end else begin
      bad = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_prdata  <= rdat;
      o_pslverr <= i_psel & ~i_penable & bad;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_ack_on_rx: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    i_rx_valid |=> ack_r)
    else $error("ack not set");
  a_ack_clear: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (state_r == ANNP_ST_SEND && i_tx_taken && !i_rx_valid) |=> !ack_r)
    else $error("ack not cleared after send");
  a_tog_invert: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (state_r == ANNP_ST_SEND && i_tx_taken && !i_rx_valid)
    |=> tog_r != $past(o_tx_word[ANNP_B_TOG]))
    else $error("toggle not inverted");
  a_rx_capture: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    i_rx_valid |=> rxpg_r == $past(i_rx_word))
    else $error("rx page lost");
  a_pgrx_set: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    i_rx_valid |=> pgrx_r)
    else $error("page flag not set");
  a_pgrx_clr: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (rd && i_paddr == ANNP_ADDR_EXP && pgrx_seen && !i_rx_valid)
    |=> !pgrx_r)
    else $error("page flag not cleared");
  a_pgrx_keep: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_psel && !i_penable && i_paddr == ANNP_ADDR_EXP && i_rx_valid &&
     !pgrx_r) |=> ##1 pgrx_r)
    else $error("page flag lost during read");
  a_tx_word_send: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (state_r == ANNP_ST_IDLE && send_req_r) |=>
    o_tx_valid && o_tx_word[ANNP_CODE_W-1:0] == $past(code_r))
    else $error("tx word wrong");
  a_tx_hold: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_tx_valid && !i_tx_taken) |=> o_tx_valid && $stable(o_tx_word))
    else $error("tx page dropped before taken");
  a_tx_fields: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr && i_paddr == ANNP_ADDR_TX) |=>
    more_r == $past(i_pwdata[ANNP_B_MORE]) &&
    msg_r == $past(i_pwdata[ANNP_B_MSG]))
    else $error("tx fields not written");
  a_code_write: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr && i_paddr == ANNP_ADDR_TX) |=>
    code_r == $past(i_pwdata[ANNP_CODE_W-1:0]))
    else $error("code not written");
  a_irq_level: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    o_irq == $past(|(istat_r & imask_r)))
    else $error("irq mismatch");
  a_ready_pulse: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    o_pready |=> !o_pready)
    else $error("ready held past one cycle");

  // ****************************************
  // cover points
  // ****************************************
  c_rx_page: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    i_rx_valid ##1 pgrx_r);
  c_tx_done: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    state_r == ANNP_ST_SEND && i_tx_taken);
  c_irq: cover property (@(posedge i_mclk) disable iff (!i_resetn) o_irq);
  c_rx_during_read: cover property (@(posedge i_mclk)
    disable iff (!i_resetn)
    i_psel && !i_penable && i_paddr == ANNP_ADDR_EXP && i_rx_valid);
endmodule
`default_nettype wire

//--- testbench/annp_link_partner.sv
`default_nettype none
module annp_link_partner (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // bench control
  input  wire logic [3:0]  i_dly,
  input  wire logic        i_go,
  input  wire logic [15:0] i_page,
  // page exchange
  input  wire logic        i_tx_valid,
  output logic             o_tx_taken,
  output logic             o_rx_valid,
  output logic [15:0]      o_rx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  // take sent page after a stall
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_r <= '0;
      o_tx_taken <= 1'b0;
    end else begin
      wait_r <= i_tx_valid ? wait_r + 4'h1 : 4'h0;
      o_tx_taken <= i_tx_valid && !o_tx_taken && wait_r >= i_dly;
    end
  end
  // idle word flips so stale data never looks valid
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_valid <= 1'b0;
      o_rx_word <= '0;
    end else begin
      o_rx_valid <= i_go;
      o_rx_word <= i_go ? i_page : ~o_rx_word;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import annp_pkg::*;
  logic clk, rstn, psel, penable, pwrite, go, rxv, taken, irq, txv, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, lf;
  logic [15:0] page, rxw, txw, w;
  logic [3:0] dly;
  logic tog;
  logic rdy;
  logic [32:0] expq[$];
  int error_cnt, n_checks;
  annp_regs i_dut (.i_mclk(clk), .i_resetn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(rdy), .o_pslverr(perr),
    .i_rx_valid(rxv), .i_rx_word(rxw), .i_tx_taken(taken),
    .o_tx_valid(txv), .o_tx_word(txw), .o_irq(irq));
  annp_link_partner i_lp (.i_mclk(clk), .i_resetn(rstn), .i_dly(dly),
    .i_go(go), .i_page(page), .i_tx_valid(txv), .o_tx_taken(taken),
    .o_rx_valid(rxv), .o_rx_word(rxw));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h000000c5 : 32'h0);
  endfunction
  task automatic chk(input logic [32:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; reads note the expected {pslverr, prdata}
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    int n;
    @(posedge clk);
    if (!wr) expq.push_back(exp);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      results();
    end else begin
      psel <= 0;
      penable <= 0;
    end
  endtask
  task automatic waitv(input logic lvl);
    int n;
    n = 0;
    while (txv !== lvl && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      results();
    end
  endtask
  always @(posedge clk) begin
    if (rdy === 1'b1 && psel && penable && !pwrite) begin
      if (expq.size() == 0) chk(33'h1, 33'h0, "queue");
      else chk({perr, prdata}, expq.pop_front(), "prdata");
    end
  end
  initial begin
    {rstn, psel, penable, pwrite, go} = '0;
    paddr = '0;
    pwdata = '0;
    page = '0;
    dly = '0;
    tog = 0;
    lf = 32'h41c2;
    repeat (4) @(posedge clk);
    rstn <= 1;
    apb(0, ANNP_ADDR_TX, 0, 33'h2001);
    apb(0, ANNP_ADDR_RX, 0, 33'h2001);
    apb(0, ANNP_ADDR_EXP, 0, 33'h0);
    apb(0, 8'h04, 0, {1'b1, 32'h0});
    apb(1, ANNP_ADDR_TX, 32'hffff, 0);
    apb(0, ANNP_ADDR_TX, 0, 33'hb7ff);
    apb(1, ANNP_ADDR_IMASK, 0, 0);
    for (int k = 0; k < 3; k++) begin
      lf = lfsr(lfsr(lf));
      dly <= 4'(k * 5);
      page <= lf[15:0];
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (3) @(posedge clk);
      apb(0, ANNP_ADDR_RX, 0, {17'h0, lf[15:0]});
      apb(0, ANNP_ADDR_EXP, 0, 33'h2);
      apb(0, ANNP_ADDR_EXP, 0, 33'h0);
      w = lf[31:16];
      apb(1, ANNP_ADDR_TX, {16'h0, w}, 0);
      apb(1, ANNP_ADDR_CTRL, 32'h1, 0);
      // page stays busy until the partner takes it
      apb(0, ANNP_ADDR_CTRL, 0, 33'h1);
      waitv(1);
      chk(txw, {w[15], 1'b1, w[13:12], tog, w[10:0]}, "txw");
      waitv(0);
      tog = ~tog;
      apb(0, ANNP_ADDR_TX, 0, {w[15], 1'b0, w[13:12], tog, w[10:0]});
    end
    // a page landing in the read's setup cycle must not be lost
    lf = lfsr(lf);
    page <= lf[15:0];
    go <= 1;
    fork
      apb(0, ANNP_ADDR_EXP, 0, 33'h0);
      begin
        @(posedge clk);
        go <= 0;
      end
    join
    apb(0, ANNP_ADDR_EXP, 0, 33'h2);
    apb(0, ANNP_ADDR_RX, 0, {17'h0, lf[15:0]});
    chk(irq, 0, "irq masked");
    apb(0, ANNP_ADDR_ISTAT, 0, 33'h3);
    apb(1, ANNP_ADDR_IMASK, 32'h1, 0);
    repeat (3) @(posedge clk);
    chk(irq, 1, "irq");
    apb(1, ANNP_ADDR_ISTAT, 32'h3, 0);
    repeat (3) @(posedge clk);
    chk(irq, 0, "irq clr");
    apb(0, ANNP_ADDR_ISTAT, 0, 33'h0);
    repeat (3) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
